//--- gsr_service_request.sv
/*
   Service-request and serial-poll status logic of the bus
   interface, with the reference-memory block sender.
   Assumes event, command and memory ports on sys_clk; the
   serial-poll pins are asynchronous; memory read is combinational.
*/
// Functional notes
// RULE1 - Top status bit is unused and always reads zero.
// RULE2 - Service-request flag is set whenever SRQ is being asserted.
// RULE3 - Abnormal flag is one after an error, zero for normal conditions.
// RULE4 - Busy flag is one while acquisition runs, zero once stopped.
// RULE5 - Four-bit status code tells up to sixteen conditions.
// RULE6 - Controller trusts the status byte only after a service request.
// RULE7 - Normal codes: 0001 acquisition stopped, 0010 compare stop.
// RULE8 - Abnormal code 0111 on received checksum failure.
// RULE9 - Abnormal code 1000 for bad menu or forbidden menu change.
// RULE10 - Code 1011 for separator fault, 1111 for syntax error.
// RULE11 - Code 1101 for too much data, 1110 for too few.
// RULE12 - Every abnormal condition always raises a service request.
// RULE13 - Normal conditions request service only when enabled; enables clear at reset.
// RULE14 - Commands enable normal requests all at once or singly.
// RULE15 - Commands disable normal requests all at once or singly.
// RULE16 - No parallel poll answer; status only by serial poll.
// RULE17 - Dump sends header, separator, preamble, length, data, checksum, separator.
// RULE18 - Dump block always has the same fixed length.
// RULE19 - Controller treats bytes of absent hardware as invalid.
// RULE20 - Key commands get no acknowledgement or result.
// RULE21 - During serial poll the status byte is put on the data lines.
// RULE22 - Request on line 7, abnormal on line 6, busy on line 5.
// RULE23 - Checksum is the modulo-256 sum of all data bytes.
// RULE24 - Status code sits on data lines 1 to 4.
`timescale 1ns/10ps
module gsr_service_request #(
   parameter int DATA_CNT = gsr_pkg::DATA_CNT,
   parameter int AW       = $clog2(DATA_CNT)
) (
   input  wire logic                           sys_clk,
   input  wire logic                           reset,
   input  wire logic [gsr_pkg::ABN_EVENTS-1:0] abnEvt,
   input  wire logic                           acqStopEvt,
   input  wire logic                           cmpStopEvt,
   input  wire logic                           acqRunning,
   input  wire logic                           cmdValid,
   input  wire logic [3:0]                     cmdCode,
   input  wire logic                           spollPin,
   input  wire logic                           acceptPin,
   output logic                                srqOut,
   output logic                                srqDrive_n,
   output logic      [7:0]                     dioOut,
   output logic                                dioDrive_n,
   output logic      [7:0]                     pollStatusByte,
   output logic      [1:0]                     normalEnables,
   output logic      [AW-1:0]                  memAddr,
   input  wire logic [7:0]                     memData,
   output logic                                txValid,
   input  wire logic                           txReady,
   output logic      [7:0]                     txByte,
   output logic                                dumpBusy
);
   localparam logic [15:0] LEN_TOTAL = 16'(DATA_CNT + 1);
   localparam logic [AW-1:0] LAST_IDX = AW'(DATA_CNT - 1);

   // ----------------------------------------------------------
   // Pin synchronisers and poll strobes
   // ----------------------------------------------------------
   logic [1:0] pinSync;
   logic       spollSync;
   logic       acceptSync;
   logic       acceptSeen_r;
   logic       pollDone;

   gsr_sync #(
      .WIDTH (2)
   ) u_sync (
      .sys_clk (sys_clk),
      .reset   (reset),
      .asyncIn ({acceptPin, spollPin}),
      .syncOut (pinSync)
   );

   assign spollSync  = pinSync[0];
   assign acceptSync = pinSync[1];

   always_ff @(posedge sys_clk)
   begin
      if (reset)
         acceptSeen_r <= 1'b0;
      else
         acceptSeen_r <= acceptSync;
   end

   assign pollDone = spollSync & acceptSync & ~acceptSeen_r;

   // ----------------------------------------------------------
   // Condition encoding
   // ----------------------------------------------------------
   logic       abnHit;
   logic [3:0] abnCode;
   logic       nrmHit;
   logic [1:0] nrmSel;
   logic [3:0] nrmCode;
   logic       nrmEnHit;

   gsr_code_encoder u_enc (
      .abnEvt     (abnEvt),
      .acqStopEvt (acqStopEvt),
      .cmpStopEvt (cmpStopEvt),
      .abnHit     (abnHit),
      .abnCode    (abnCode),
      .nrmHit     (nrmHit),
      .nrmSel     (nrmSel),
      .nrmCode    (nrmCode)
   );

   // ----------------------------------------------------------
   // Normal request enables
   // ----------------------------------------------------------
   logic [1:0] enables_r;
   logic       dumpStart;

   // Other codes but the dump, key commands among them, are dropped silently
   always_ff @(posedge sys_clk)
   begin
      if (reset)
         enables_r <= gsr_pkg::ENABLES_RESET; // RULE13
      else if (cmdValid)
      begin
         case (cmdCode) // RULE20
            gsr_pkg::CMD_ENABLE_ALL:  enables_r <= 2'b11; // RULE14
            gsr_pkg::CMD_ENABLE_ONE:  enables_r[0] <= 1'b1; // RULE14
            gsr_pkg::CMD_ENABLE_TWO:  enables_r[1] <= 1'b1; // RULE14
            gsr_pkg::CMD_DISABLE_ALL: enables_r <= 2'b00; // RULE15
            gsr_pkg::CMD_DISABLE_ONE: enables_r[0] <= 1'b0; // RULE15
            gsr_pkg::CMD_DISABLE_TWO: enables_r[1] <= 1'b0; // RULE15
            default:                  enables_r <= enables_r;
         endcase
      end
   end

   assign normalEnables = enables_r;
   assign nrmEnHit      = nrmHit & |(nrmSel & enables_r); // RULE13
   assign dumpStart     = cmdValid & (cmdCode == gsr_pkg::CMD_REF_DUMP);

   // ----------------------------------------------------------
   // Status flags and code
   // ----------------------------------------------------------
   logic [3:0] code_r;
   logic       abnormal_r;
   logic       srq_r;
   logic       srq_nxt;

   // New request wins over the clear by a finished poll
   always_comb
   begin
      srq_nxt = srq_r & ~pollDone;
      if (abnHit)
         srq_nxt = 1'b1; // RULE12
      else if (nrmEnHit)
         srq_nxt = 1'b1; // RULE13
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
         srq_r <= 1'b0;
      else
         srq_r <= srq_nxt;
   end

   // Pending abnormal report is not overwritten by a normal one
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         code_r     <= gsr_pkg::CODE_NONE;
         abnormal_r <= 1'b0;
      end
      else if (abnHit)
      begin
         code_r     <= abnCode; // RULE5
         abnormal_r <= 1'b1; // RULE3
      end
      else if (nrmHit && !(srq_r && abnormal_r && !pollDone))
      begin
         code_r     <= nrmCode; // RULE7
         abnormal_r <= 1'b0; // RULE3
      end
   end

   // ----------------------------------------------------------
   // Status byte and bus drive
   // ----------------------------------------------------------
   logic [7:0] statusNow;
   logic [7:0] status_r;
   logic [7:0] dio_r;
   logic       dioDrive_r;

   always_comb
   begin
      statusNow = gsr_pkg::STATUS_RESET;
      statusNow[gsr_pkg::UNUSED_TOP_BIT]  = 1'b0; // RULE1
      statusNow[gsr_pkg::SERVICE_REQ_BIT] = srq_r; // RULE2 RULE22
      statusNow[gsr_pkg::ABNORMAL_BIT]    = abnormal_r; // RULE22
      statusNow[gsr_pkg::ACQ_RUNNING_BIT] = acqRunning; // RULE4 RULE22
      statusNow[gsr_pkg::CODE_MSB:0]      = code_r; // RULE24
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
         status_r <= gsr_pkg::STATUS_RESET;
      else
         status_r <= statusNow;
   end

   // Lines driven only in serial poll; no parallel poll path
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         dio_r      <= gsr_pkg::STATUS_RESET;
         dioDrive_r <= 1'b0;
      end
      else
      begin
         dio_r      <= spollSync ? statusNow : gsr_pkg::STATUS_RESET; // RULE21
         dioDrive_r <= spollSync; // RULE16
      end
   end

   assign pollStatusByte = status_r;
   assign dioOut         = dio_r;
   assign dioDrive_n     = ~dioDrive_r;
   assign srqOut         = 1'b0;
   assign srqDrive_n     = ~srq_r; // RULE2

   // ----------------------------------------------------------
   // Reference-memory block sender
   // ----------------------------------------------------------
   gsr_pkg::gsr_tx_state_t state_r;
   logic [7:0]    byte_r;
   logic [7:0]    sum_r;
   logic [AW-1:0] addr_r;
   logic [AW-1:0] idx_r;
   logic          accept;

   assign accept = txValid & txReady;

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         state_r <= gsr_pkg::TX_IDLE;
         byte_r  <= 8'h00;
      end
      else
      begin
         case (state_r) // RULE17
            gsr_pkg::TX_IDLE:
               if (dumpStart)
               begin
                  state_r <= gsr_pkg::TX_HDR1;
                  byte_r  <= gsr_pkg::HDR_FIRST;
               end
            gsr_pkg::TX_HDR1:
               if (accept)
               begin
                  state_r <= gsr_pkg::TX_HDR2;
                  byte_r  <= gsr_pkg::HDR_SECOND;
               end
            gsr_pkg::TX_HDR2:
               if (accept)
               begin
                  state_r <= gsr_pkg::TX_SEP1;
                  byte_r  <= gsr_pkg::SEP_SPACE;
               end
            gsr_pkg::TX_SEP1:
               if (accept)
               begin
                  state_r <= gsr_pkg::TX_PRE1;
                  byte_r  <= gsr_pkg::PRE_HASH;
               end
            gsr_pkg::TX_PRE1:
               if (accept)
               begin
                  state_r <= gsr_pkg::TX_PRE2;
                  byte_r  <= gsr_pkg::PRE_BINARY;
               end
            gsr_pkg::TX_PRE2:
               if (accept)
               begin
                  state_r <= gsr_pkg::TX_LENH;
                  byte_r  <= LEN_TOTAL[15:8]; // RULE18
               end
            gsr_pkg::TX_LENH:
               if (accept)
               begin
                  state_r <= gsr_pkg::TX_LENL;
                  byte_r  <= LEN_TOTAL[7:0]; // RULE18
               end
            gsr_pkg::TX_LENL:
               if (accept)
               begin
                  state_r <= gsr_pkg::TX_DATA;
                  byte_r  <= memData;
               end
            gsr_pkg::TX_DATA:
               if (accept)
               begin
                  if (idx_r == LAST_IDX) // RULE18
                  begin
                     state_r <= gsr_pkg::TX_CSUM;
                     byte_r  <= 8'(sum_r + byte_r); // RULE23
                  end
                  else
                     byte_r <= memData;
               end
            gsr_pkg::TX_CSUM:
               if (accept)
               begin
                  state_r <= gsr_pkg::TX_SEP2;
                  byte_r  <= gsr_pkg::SEP_NEWLINE;
               end
            gsr_pkg::TX_SEP2:
               if (accept)
                  state_r <= gsr_pkg::TX_IDLE;
            default:
               state_r <= gsr_pkg::TX_IDLE;
         endcase
      end
   end

   // Memory address runs one ahead of the byte on the stream
   always_ff @(posedge sys_clk)
   begin
      if (reset || state_r == gsr_pkg::TX_IDLE)
      begin
         addr_r <= '0;
         idx_r  <= '0;
         sum_r  <= 8'h00;
      end
      else if (accept && state_r == gsr_pkg::TX_LENL)
         addr_r <= AW'(1);
      else if (accept && state_r == gsr_pkg::TX_DATA)
      begin
         addr_r <= AW'(addr_r + 1'b1);
         idx_r  <= AW'(idx_r + 1'b1);
         sum_r  <= 8'(sum_r + byte_r); // RULE23
      end
   end

   assign memAddr  = addr_r;
   assign txByte   = byte_r;
   assign txValid  = (state_r != gsr_pkg::TX_IDLE);
   assign dumpBusy = txValid;

   // ----------------------------------------------------------
   // Checks
   // ----------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   int unsigned frameCnt;
   logic [7:0]  refSum;

   always_ff @(posedge sys_clk)
   begin
      if (reset || (dumpStart && !txValid))
      begin
         frameCnt <= 0;
         refSum   <= 8'h00;
      end
      else if (accept)
      begin
         frameCnt <= frameCnt + 1;
         if (state_r == gsr_pkg::TX_DATA)
            refSum <= 8'(refSum + txByte);
      end
   end

   a_top_bit_zero: assert property ( // RULE1
      dioDrive_r |-> !dioOut[gsr_pkg::UNUSED_TOP_BIT])
      else $error("Top status bit driven high");

   a_srq_flag_match: assert property ( // RULE2
      ##1 (!srqDrive_n == pollStatusByte[gsr_pkg::SERVICE_REQ_BIT]) || $changed(srq_r))
      else $error("Request flag differs from SRQ drive");

   a_abnormal_request: assert property ( // RULE12
      abnHit |=> srq_r && abnormal_r && code_r == $past(abnCode))
      else $error("Abnormal event did not request service");

   a_checksum_code: assert property ( // RULE8
      abnEvt == 6'h01 |=> code_r == 4'h7 ##1 pollStatusByte[3:0] == 4'h7)
      else $error("Checksum error code wrong");

   a_normal_masked: assert property ( // RULE13
      !srq_r && nrmHit && !abnHit && (nrmSel & enables_r) == 2'b00 |=> !srq_r)
      else $error("Disabled normal condition requested service");

   a_enable_all: assert property ( // RULE14
      cmdValid && cmdCode == 4'h0 |=> enables_r == 2'b11)
      else $error("Enable-all command failed");

   a_disable_one: assert property ( // RULE15
      cmdValid && cmdCode == 4'h6 |=> !enables_r[0] && $stable(enables_r[1]))
      else $error("Disable-one command failed");

   a_busy_on_byte: assert property ( // RULE4
      acqRunning [*2] |=> pollStatusByte[gsr_pkg::ACQ_RUNNING_BIT])
      else $error("Busy flag not shown");

   a_poll_drive: assert property ( // RULE21
      spollSync |=> !dioDrive_n && dioOut[6:0] == $past(statusNow[6:0]))
      else $error("Status not placed on data lines");

   a_poll_clears: assert property ( // RULE2
      pollDone && !abnHit && !nrmEnHit |=> !srq_r && srqDrive_n)
      else $error("Finished poll did not release SRQ");

   a_frame_head: assert property ( // RULE17
      state_r == gsr_pkg::TX_IDLE && dumpStart |=> txValid && txByte == 8'h4C)
      else $error("Block does not open with header");

   a_fixed_length: assert property ( // RULE18
      accept && state_r == gsr_pkg::TX_SEP2 |-> frameCnt == DATA_CNT + 8)
      else $error("Block length not fixed");

   a_sum_byte: assert property ( // RULE23
      state_r == gsr_pkg::TX_CSUM |-> txByte == refSum)
      else $error("Checksum byte wrong");

   c_abnormal_srq: cover property (abnHit ##1 pollDone);
   c_normal_srq: cover property (nrmEnHit ##[1:20] pollDone);
   c_dump_done: cover property (accept && state_r == gsr_pkg::TX_SEP2);
   c_stalled_data: cover property (state_r == gsr_pkg::TX_DATA && !txReady);

endmodule // gsr_service_request

//--- gsr_pkg.sv
/*
   Constants for the service-request status block: status byte
   layout, condition codes, command codes and block framing bytes.
   Assumes nothing beyond a SystemVerilog compiler.
*/
package gsr_pkg;

   // ----------------------------------------------------------
   // Status byte layout
   // ----------------------------------------------------------
   localparam int UNUSED_TOP_BIT     = 7;
   localparam int SERVICE_REQ_BIT    = 6;
   localparam int ABNORMAL_BIT       = 5;
   localparam int ACQ_RUNNING_BIT    = 4;
   localparam int CODE_MSB           = 3;
   localparam logic [7:0] STATUS_RESET = 8'h00;

   // ----------------------------------------------------------
   // Condition codes
   // ----------------------------------------------------------
   localparam logic [3:0] CODE_NONE      = 4'h0;
   localparam logic [3:0] CODE_ACQ_STOP  = 4'h1;
   localparam logic [3:0] CODE_CMP_STOP  = 4'h2;
   localparam logic [3:0] CODE_CHECKSUM  = 4'h7;
   localparam logic [3:0] CODE_MENU      = 4'h8;
   localparam logic [3:0] CODE_SEPARATOR = 4'hB;
   localparam logic [3:0] CODE_TOO_MUCH  = 4'hD;
   localparam logic [3:0] CODE_TOO_FEW   = 4'hE;
   localparam logic [3:0] CODE_SYNTAX    = 4'hF;
   localparam int ABN_EVENTS = 6;
   // Abnormal event index 0..5, lowest index wins
   localparam logic [23:0] ABN_CODE_TABLE = {CODE_SYNTAX, CODE_TOO_FEW,
      CODE_TOO_MUCH, CODE_SEPARATOR, CODE_MENU, CODE_CHECKSUM};

   // ----------------------------------------------------------
   // Command codes
   // ----------------------------------------------------------
   localparam logic [3:0] CMD_ENABLE_ALL  = 4'h0;
   localparam logic [3:0] CMD_ENABLE_ONE  = 4'h1;
   localparam logic [3:0] CMD_ENABLE_TWO  = 4'h2;
   localparam logic [3:0] CMD_DISABLE_ALL = 4'h5;
   localparam logic [3:0] CMD_DISABLE_ONE = 4'h6;
   localparam logic [3:0] CMD_DISABLE_TWO = 4'h7;
   localparam logic [3:0] CMD_REF_DUMP    = 4'h8;
   localparam logic [1:0] ENABLES_RESET   = 2'h0;

   // ----------------------------------------------------------
   // Reference-memory block framing
   // ----------------------------------------------------------
   localparam int DATA_CNT            = 10280;
   localparam logic [7:0] HDR_FIRST   = 8'h4C;
   localparam logic [7:0] HDR_SECOND  = 8'h52;
   localparam logic [7:0] SEP_SPACE   = 8'h20;
   localparam logic [7:0] PRE_HASH    = 8'h23;
   localparam logic [7:0] PRE_BINARY  = 8'h42;
   localparam logic [7:0] SEP_NEWLINE = 8'h0A;
   localparam int FRAME_EXTRA         = 9;

   typedef enum {
      TX_IDLE, TX_HDR1, TX_HDR2, TX_SEP1, TX_PRE1, TX_PRE2,
      TX_LENH, TX_LENL, TX_DATA, TX_CSUM, TX_SEP2
   } gsr_tx_state_t;

endpackage

//--- gsr_sync.sv
/*
   Two-flop synchroniser, one per bit.
   Assumes asynchronous inputs and a sys_clk destination.
*/
`timescale 1ns/10ps
module gsr_sync #(
   parameter int WIDTH = 2
) (
   input  wire logic             sys_clk,
   input  wire logic             reset,
   input  wire logic [WIDTH-1:0] asyncIn,
   output wire logic [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] stage1_r;
   logic [WIDTH-1:0] stage2_r;

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++)
      begin : g_bit
         always_ff @(posedge sys_clk)
         begin
            if (reset)
            begin
               stage1_r[i] <= 1'b0;
               stage2_r[i] <= 1'b0;
            end
            else
            begin
               stage1_r[i] <= asyncIn[i];
               stage2_r[i] <= stage1_r[i];
            end
         end
      end
   endgenerate

   assign syncOut = stage2_r;
endmodule // gsr_sync

//--- gsr_code_encoder.sv
/*
   Condition encoder: maps event strobes to a status code.
   Assumes one-cycle event strobes on sys_clk.
*/
`timescale 1ns/10ps
module gsr_code_encoder (
   input  wire logic [gsr_pkg::ABN_EVENTS-1:0] abnEvt,
   input  wire logic                           acqStopEvt,
   input  wire logic                           cmpStopEvt,
   output logic                                abnHit,
   output logic      [3:0]                     abnCode,
   output logic                                nrmHit,
   output logic      [1:0]                     nrmSel,
   output logic      [3:0]                     nrmCode
);
   always_comb
   begin
      abnHit  = 1'b0;
      abnCode = gsr_pkg::CODE_NONE;
      for (int k = gsr_pkg::ABN_EVENTS - 1; k >= 0; k--)
      begin
         if (abnEvt[k])
         begin
            abnHit  = 1'b1;
            abnCode = gsr_pkg::ABN_CODE_TABLE[k*4 +: 4]; // RULE8 RULE9 RULE10 RULE11
         end
      end
   end

   // Stop by compare is the more specific normal condition
   always_comb
   begin
      nrmHit  = acqStopEvt | cmpStopEvt;
      nrmSel  = cmpStopEvt ? 2'b10 : (acqStopEvt ? 2'b01 : 2'b00);
      nrmCode = cmpStopEvt ? gsr_pkg::CODE_CMP_STOP : gsr_pkg::CODE_ACQ_STOP; // RULE7
   end
endmodule // gsr_code_encoder

//--- gsr_poll_ctrl.sv
/*
   Bus controller model: serial-polls the device once it requests service.
   Assumes the bench raises pollReq and waits for a pollOk pulse.
*/
`timescale 1ns/10ps
module gsr_poll_ctrl (
   input  wire logic       sys_clk,
   input  wire logic       srqDrive_n,
   input  wire logic [7:0] dioOut,
   input  wire logic       dioDrive_n,
   input  wire logic       pollReq,
   input  wire logic       slowAccept,
   output logic            spollPin,
   output logic            acceptPin,
   output logic      [7:0] polledByte,
   output logic            pollOk
);
   int n;
   // ----------------------------------------------------------
   // Poll sequence
   // ----------------------------------------------------------
   initial
   begin
      spollPin   = 1'b0;
      acceptPin  = 1'b0;
      pollOk     = 1'b0;
      polledByte = 8'hFF;
      forever
      begin
         @(negedge sys_clk);
         pollOk = 1'b0;
         if (pollReq && srqDrive_n === 1'b0)
         begin
            spollPin = 1'b1;
            for (n = 0; n < 8 && dioDrive_n !== 1'b0; n++)
               @(negedge sys_clk);
            // Undriven lines read at the pull-up level
            polledByte = (dioDrive_n === 1'b0) ? dioOut : 8'hFF;
            repeat (slowAccept ? 5 : 1) @(negedge sys_clk);
            acceptPin = 1'b1;
            repeat (4) @(negedge sys_clk);
            spollPin  = 1'b0;
            acceptPin = 1'b0;
            repeat (4) @(negedge sys_clk);
            pollOk = 1'b1;
         end
      end
   end
endmodule // gsr_poll_ctrl

//--- gsr_service_request_tb.sv
/*
   Bench of the service-request block: event table, abnormal priority, reset and dump.
   Assumes the controller model gsr_poll_ctrl on the poll pins.
*/
`timescale 1ns/10ps
module gsr_service_request_tb;
   localparam int NDB = 8;
   localparam int AW  = 3;
   typedef struct packed {
      logic [3:0] cmd;
      logic [5:0] abn;
      logic [3:0] flg; // acq, cmp, run, req
      logic [1:0] en;
      logic [7:0] sb;
   } gsr_row_t;
   logic          sys_clk, reset, acqStopEvt, cmpStopEvt, acqRunning, cmdValid, txReady, pollReq, slowAccept;
   logic [5:0]    abnEvt;
   logic [3:0]    cmdCode;
   wire logic     srqDrive_n, dioDrive_n, spollPin, acceptPin, txValid, pollOk, srqOut, dumpBusy;
   wire logic [7:0] dioOut, pollStatusByte, txByte, polledByte, memData;
   wire logic [1:0] normalEnables;
   wire logic [AW-1:0] memAddr;
   int            mismatches, testsRun, cycles, i, k, d;
   gsr_row_t      r;
   logic [7:0]    q[$], e[$], b, sum;
   logic [15:0]   lenW;
   gsr_row_t      rows[14] = '{'{4'h3, 6'h00, 4'h8, 2'h0, 8'h01}, '{4'h1, 6'h00, 4'h9, 2'h1, 8'h41},
      '{4'h6, 6'h00, 4'hA, 2'h0, 8'h11}, '{4'h2, 6'h00, 4'h7, 2'h2, 8'h52}, '{4'h7, 6'h00, 4'h4, 2'h0, 8'h02},
      '{4'h0, 6'h00, 4'hD, 2'h3, 8'h42}, '{4'h5, 6'h00, 4'h6, 2'h0, 8'h12}, '{4'h9, 6'h01, 4'h1, 2'h0, 8'h67},
      '{4'hF, 6'h02, 4'h3, 2'h0, 8'h78}, '{4'hF, 6'h04, 4'h1, 2'h0, 8'h6B}, '{4'hF, 6'h08, 4'h1, 2'h0, 8'h6D},
      '{4'hF, 6'h10, 4'h1, 2'h0, 8'h6E}, '{4'hF, 6'h20, 4'h1, 2'h0, 8'h6F}, '{4'hF, 6'h34, 4'h3, 2'h0, 8'h7B}};

   assign memData = 8'h33 + 8'h1D * {5'h00, memAddr};

   gsr_service_request #(.DATA_CNT(NDB), .AW(AW)) gsr_service_request_inst (.sys_clk(sys_clk), .reset(reset),
      .abnEvt(abnEvt), .acqStopEvt(acqStopEvt), .cmpStopEvt(cmpStopEvt), .acqRunning(acqRunning),
      .cmdValid(cmdValid), .cmdCode(cmdCode), .spollPin(spollPin), .acceptPin(acceptPin), .srqOut(srqOut),
      .srqDrive_n(srqDrive_n), .dioOut(dioOut), .dioDrive_n(dioDrive_n), .pollStatusByte(pollStatusByte),
      .normalEnables(normalEnables), .memAddr(memAddr), .memData(memData), .txValid(txValid),
      .txReady(txReady), .txByte(txByte), .dumpBusy(dumpBusy));
   gsr_poll_ctrl gsr_poll_ctrl_inst (.sys_clk(sys_clk), .srqDrive_n(srqDrive_n), .dioOut(dioOut),
      .dioDrive_n(dioDrive_n), .pollReq(pollReq), .slowAccept(slowAccept), .spollPin(spollPin),
      .acceptPin(acceptPin), .polledByte(polledByte), .pollOk(pollOk));

   // ----------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------
   task chk_byte(input logic [7:0] got, input logic [7:0] exp);
      testsRun++;
      if (got !== exp)
      begin
         mismatches++;
         $display("BAD t=%0t byte got %h expected %h", $time, got, exp);
      end
   endtask
   task chk_bit(input logic got, input logic exp);
      testsRun++;
      if (got !== exp)
      begin
         mismatches++;
         $display("BAD t=%0t bit got %b expected %b", $time, got, exp);
      end
   endtask
   task report_and_stop();
      $display("comparisons %0d mismatches %0d", testsRun, mismatches);
      if (mismatches == 0 && testsRun > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task send_cmd(input logic [3:0] c);
      @(negedge sys_clk);
      cmdCode  = c;
      cmdValid = 1'b1;
      @(negedge sys_clk);
      cmdValid = 1'b0;
   endtask
   task pulse(input logic [5:0] a, input logic s, input logic c);
      @(negedge sys_clk);
      abnEvt     = a;
      acqStopEvt = s;
      cmpStopEvt = c;
      @(negedge sys_clk);
      abnEvt     = 6'h00;
      acqStopEvt = 1'b0;
      cmpStopEvt = 1'b0;
   endtask
   task do_poll(input logic slow, input logic [7:0] sb);
      slowAccept = slow;
      pollReq    = 1'b1;
      for (k = 0; k < 60 && pollOk !== 1'b1; k++)
         @(posedge sys_clk);
      @(negedge sys_clk);
      pollReq = 1'b0;
      chk_byte(polledByte, sb);
      chk_bit(srqDrive_n, 1'b1);
      chk_byte(pollStatusByte, sb & 8'hBF);
   endtask

   initial
   begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 4000)
      begin
         mismatches++;
         report_and_stop();
      end
   end

   // ----------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------
   initial
   begin
      {acqStopEvt, cmpStopEvt, acqRunning, cmdValid, txReady, pollReq, slowAccept} = 7'h00;
      abnEvt  = 6'h00;
      cmdCode = 4'h0;
      reset   = 1'b1;
      repeat (16) @(negedge sys_clk);
      reset = 1'b0;
      for (i = 0; i < 14; i++)
      begin
         r = rows[i];
         acqRunning = r.flg[1];
         send_cmd(r.cmd);
         pulse(r.abn, r.flg[3], r.flg[2]);
         repeat (3) @(negedge sys_clk);
         chk_bit(srqDrive_n, !r.flg[0]);
         chk_bit(srqOut, 1'b0);
         chk_byte(pollStatusByte, r.sb);
         chk_byte({6'h00, normalEnables}, {6'h00, r.en});
         chk_bit(dioDrive_n, 1'b1);
         if (r.flg[0])
            do_poll(i[1], r.sb);
      end
      // Normal event while an abnormal report waits
      acqRunning = 1'b0;
      send_cmd(gsr_pkg::CMD_ENABLE_ALL);
      pulse(6'h20, 1'b0, 1'b0);
      pulse(6'h00, 1'b1, 1'b0);
      repeat (3) @(negedge sys_clk);
      chk_byte(pollStatusByte, 8'h6F);
      do_poll(1'b0, 8'h6F);
      // Mid-run reset with a request pending
      pulse(6'h01, 1'b0, 1'b0);
      reset = 1'b1;
      repeat (2) @(negedge sys_clk);
      reset = 1'b0;
      chk_byte({6'h00, normalEnables}, 8'h00);
      chk_byte(pollStatusByte, 8'h00);
      pulse(6'h00, 1'b1, 1'b0);
      repeat (3) @(negedge sys_clk);
      chk_bit(srqDrive_n, 1'b1);
      // Reference dump, twice, with a stalling sink
      lenW = 16'(NDB + 1);
      e = '{gsr_pkg::HDR_FIRST, gsr_pkg::HDR_SECOND, 8'h20, 8'h23, 8'h42, lenW[15:8], lenW[7:0]};
      sum = 8'h00;
      for (k = 0; k < NDB; k++)
      begin
         b = 8'h33 + 8'h1D * 8'(k);
         e.push_back(b);
         sum = sum + b;
      end
      e.push_back(sum);
      e.push_back(8'h0A);
      for (d = 0; d < 2; d++)
      begin
         q = {};
         send_cmd(gsr_pkg::CMD_REF_DUMP);
         for (k = 0; k < 300 && !(k > 2 && txValid !== 1'b1); k++)
         begin
            @(negedge sys_clk);
            txReady  = (k % 3 != 2);
            cmdValid = (k == 6);
            if (txValid === 1'b1 && txReady)
               q.push_back(txByte);
            if (k == 6)
               chk_bit(dumpBusy, 1'b1);
         end
         txReady = 1'b0;
         chk_bit(dumpBusy, 1'b0);
         chk_byte(8'(q.size()), 8'(e.size()));
         for (k = 0; k < e.size(); k++)
            chk_byte(q[k], e[k]);
      end
      report_and_stop();
   end
endmodule // gsr_service_request_tb
